/* File: cardbus_cfg_consts.svh */
// Offsets, field positions, reset values and fixed codes of the mid configuration header.
`ifndef CARDBUS_CFG_CONSTS_SVH
`define CARDBUS_CFG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets in configuration space
// ----------------------------------------------------------------------
`define CACHE_LINE_SIZE_OFS 8'h0c
`define PRIMARY_LATENCY_TIMER_OFS 8'h0d
`define HEADER_LAYOUT_TYPE_OFS 8'h0e
`define SELF_TEST_CONTROL_OFS 8'h0f
`define SOCKET_REGISTER_BASE_OFS 8'h10
`define SECONDARY_BUS_STATUS_OFS 8'h16
`define PRIMARY_BUS_NUMBER_OFS 8'h18
`define SECONDARY_BUS_NUMBER_OFS 8'h19

// ----------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------
`define CACHE_LINE_SIZE_VALUE 8'h00
`define PRIMARY_LATENCY_RESET 5'h00
`define HEADER_LAYOUT_TYPE_VALUE 8'h02
`define SELF_TEST_CONTROL_VALUE 8'h00
`define SOCKET_BASE_RESET 20'h00000
`define SOCKET_BASE_LOW_VALUE 12'h000
`define SECONDARY_STATUS_RESET 16'h0200
`define SECONDARY_STATUS_FIXED 16'h0200
`define SECONDARY_STATUS_W1C_MASK 16'hf900
`define BUS_NUMBER_RESET 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LATENCY_FRAC_BITS 3'h0
`define SOCKET_BASE_LSB 12
`define STAT_PARITY_DETECTED 15
`define STAT_SYSTEM_ERROR 14
`define STAT_MASTER_ABORT 13
`define STAT_TARGET_ABORT_RCVD 12
`define STAT_TARGET_ABORT_SIG 11
`define STAT_DATA_PARITY 8

// ----------------------------------------------------------------------
// Socket register region layout
// ----------------------------------------------------------------------
`define SOCKET_CARDBUS_REGS_OFS 12'h000
`define SOCKET_CARD16_REGS_OFS 12'h800

`endif

/* File: cardbus_cfg_header_mid.sv */
// Configuration header offsets 0Ch to 19h of a single-socket CardBus bridge.
`include "cardbus_cfg_consts.svh"

module cardbus_cfg_header_mid
    import cardbus_cfg_pkg::*;
(
    // Clock and primary bus reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Configuration access
    input wire logic cfg_read_i,
    input wire logic cfg_write_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_byte_en_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    // Command and bridge control bits held elsewhere
    input wire logic serr_enable_i,
    input wire logic parity_response_enable_i,
    input wire logic memory_space_enable_i,
    input wire logic card_serr_enable_i,
    input wire logic [7:0] subordinate_bus_i,
    // Secondary bus events from the bridge core
    input wire logic sec_parity_error_i,
    input wire logic sec_perr_seen_as_master_i,
    input wire logic sec_master_abort_i,
    input wire logic sec_target_abort_rcvd_i,
    input wire logic sec_target_abort_sig_i,
    input wire logic card_serr_n_i,
    // Primary error pins
    output logic primary_serr_n_o,
    output logic primary_serr_oe_o,
    output logic primary_perr_request_o,
    // Socket register region decode
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    output logic socket_claim_o,
    output logic socket_card16_sel_o,
    output logic [10:0] socket_reg_offset_o,
    // Configuration forwarding
    input wire logic cfg_type1_req_i,
    input wire logic [7:0] cfg_type1_bus_i,
    input wire logic sec_type1_req_i,
    output logic fwd_type0_o,
    output logic fwd_type1_o,
    output logic primary_special_cycle_o,
    // Primary master burst control
    input wire logic burst_start_i,
    input wire logic burst_active_i,
    input wire logic grant_n_i,
    output logic latency_expired_o,
    output logic end_burst_o
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] ofs);
        dword_hit = (addr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic lane_hit(input logic [7:0] ofs, input logic [3:0] be);
        lane_hit = be[ofs[1:0]];
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] card_serr_sync_reg;
    logic [1:0] grant_sync_reg;
    logic card_serr_prev_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            card_serr_sync_reg <= 2'h3;
            grant_sync_reg <= 2'h3;
            card_serr_prev_reg <= 1'b1;
        end else begin
            card_serr_sync_reg <= {card_serr_sync_reg[0], card_serr_n_i};
            grant_sync_reg <= {grant_sync_reg[0], grant_n_i};
            card_serr_prev_reg <= card_serr_sync_reg[1];
        end
    end

    logic card_serr_event;
    assign card_serr_event = card_serr_prev_reg && !card_serr_sync_reg[1];

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    logic wr_latency;
    logic wr_base_b1;
    logic wr_base_b2;
    logic wr_base_b3;
    logic wr_status_lo;
    logic wr_status_hi;
    logic wr_primary_bus;
    logic wr_secondary_bus;

    assign wr_latency = cfg_write_i && dword_hit(cfg_addr_i, `PRIMARY_LATENCY_TIMER_OFS)
        && lane_hit(`PRIMARY_LATENCY_TIMER_OFS, cfg_byte_en_i);
    assign wr_base_b1 = cfg_write_i && dword_hit(cfg_addr_i, `SOCKET_REGISTER_BASE_OFS)
        && cfg_byte_en_i[1];
    assign wr_base_b2 = cfg_write_i && dword_hit(cfg_addr_i, `SOCKET_REGISTER_BASE_OFS)
        && cfg_byte_en_i[2];
    assign wr_base_b3 = cfg_write_i && dword_hit(cfg_addr_i, `SOCKET_REGISTER_BASE_OFS)
        && cfg_byte_en_i[3];
    assign wr_status_lo = cfg_write_i && dword_hit(cfg_addr_i, `SECONDARY_BUS_STATUS_OFS)
        && lane_hit(`SECONDARY_BUS_STATUS_OFS, cfg_byte_en_i);
    assign wr_status_hi = cfg_write_i && dword_hit(cfg_addr_i, `SECONDARY_BUS_STATUS_OFS)
        && cfg_byte_en_i[3];
    assign wr_primary_bus = cfg_write_i && dword_hit(cfg_addr_i, `PRIMARY_BUS_NUMBER_OFS)
        && lane_hit(`PRIMARY_BUS_NUMBER_OFS, cfg_byte_en_i);
    assign wr_secondary_bus = cfg_write_i && dword_hit(cfg_addr_i, `SECONDARY_BUS_NUMBER_OFS)
        && lane_hit(`SECONDARY_BUS_NUMBER_OFS, cfg_byte_en_i);

    logic [4:0] latency_reg;
    logic [19:0] socket_base_reg;
    bus_number_t primary_bus_reg;
    bus_number_t secondary_bus_reg;

    // Cache line size, header type and self-test have no storage at all.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latency_reg <= `PRIMARY_LATENCY_RESET;
        end else if (wr_latency) begin
            latency_reg <= cfg_wdata_i[15:11];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            socket_base_reg <= `SOCKET_BASE_RESET;
        end else begin
            if (wr_base_b1) begin
                socket_base_reg[3:0] <= cfg_wdata_i[15:12];
            end
            if (wr_base_b2) begin
                socket_base_reg[11:4] <= cfg_wdata_i[23:16];
            end
            if (wr_base_b3) begin
                socket_base_reg[19:12] <= cfg_wdata_i[31:24];
            end
        end
    end

    // The primary bus number feeds nothing but the read path.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            primary_bus_reg <= `BUS_NUMBER_RESET;
        end else if (wr_primary_bus) begin
            primary_bus_reg <= cfg_wdata_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            secondary_bus_reg <= `BUS_NUMBER_RESET;
        end else if (wr_secondary_bus) begin
            secondary_bus_reg <= cfg_wdata_i[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Secondary bus status
    // ------------------------------------------------------------------
    status_word_t status_reg;
    status_word_t status_set;
    status_word_t status_clr;
    status_word_t status_next;

    always_comb begin
        status_set = 16'h0000;
        status_set[`STAT_PARITY_DETECTED] = sec_parity_error_i;
        status_set[`STAT_SYSTEM_ERROR] = card_serr_event;
        status_set[`STAT_MASTER_ABORT] = sec_master_abort_i;
        status_set[`STAT_TARGET_ABORT_RCVD] = sec_target_abort_rcvd_i;
        status_set[`STAT_TARGET_ABORT_SIG] = sec_target_abort_sig_i;
        status_set[`STAT_DATA_PARITY] = sec_perr_seen_as_master_i
            && parity_response_enable_i;
    end

    always_comb begin
        status_clr = 16'h0000;
        if (wr_status_lo) begin
            status_clr[7:0] = cfg_wdata_i[23:16];
        end
        if (wr_status_hi) begin
            status_clr[15:8] = cfg_wdata_i[31:24];
        end
        // A new event in the clearing cycle survives the clear.
        status_next = (((status_reg & ~status_clr) | status_set)
            & `SECONDARY_STATUS_W1C_MASK) | `SECONDARY_STATUS_FIXED;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= `SECONDARY_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration read path
    // ------------------------------------------------------------------
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = 32'h00000000;
        if (dword_hit(cfg_addr_i, `CACHE_LINE_SIZE_OFS)) begin
            rdata_next = {`SELF_TEST_CONTROL_VALUE, `HEADER_LAYOUT_TYPE_VALUE,
                latency_reg, `LATENCY_FRAC_BITS, `CACHE_LINE_SIZE_VALUE};
        end else if (dword_hit(cfg_addr_i, `SOCKET_REGISTER_BASE_OFS)) begin
            rdata_next = {socket_base_reg, `SOCKET_BASE_LOW_VALUE};
        end else if (dword_hit(cfg_addr_i, `SECONDARY_BUS_STATUS_OFS)) begin
            rdata_next = {status_reg, 16'h0000};
        end else if (dword_hit(cfg_addr_i, `PRIMARY_BUS_NUMBER_OFS)) begin
            rdata_next = {8'h00, subordinate_bus_i, secondary_bus_reg, primary_bus_reg};
        end
    end

    // Every access is answered one clock later; offsets outside this block read zero.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_rdata_o <= 32'h00000000;
            cfg_ack_o <= 1'b0;
        end else begin
            cfg_rdata_o <= cfg_read_i ? rdata_next : 32'h00000000;
            cfg_ack_o <= cfg_read_i || cfg_write_i;
        end
    end

    // ------------------------------------------------------------------
    // Primary error signalling
    // ------------------------------------------------------------------
    // SERR is open drain: the low level is constant and only the enable moves.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            primary_serr_n_o <= 1'b0;
            primary_serr_oe_o <= 1'b0;
            primary_perr_request_o <= 1'b0;
        end else begin
            primary_serr_n_o <= 1'b0;
            primary_serr_oe_o <= card_serr_event && card_serr_enable_i
                && serr_enable_i;
            primary_perr_request_o <= sec_perr_seen_as_master_i
                && parity_response_enable_i;
        end
    end

    // ------------------------------------------------------------------
    // Socket register region decode
    // ------------------------------------------------------------------
    logic socket_base_valid;
    logic socket_addr_match;

    // Relies on software loading a non-zero base before use.
    assign socket_base_valid = (socket_base_reg != `SOCKET_BASE_RESET);
    assign socket_addr_match = (mem_addr_i[31:`SOCKET_BASE_LSB] == socket_base_reg);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            socket_claim_o <= 1'b0;
            socket_card16_sel_o <= 1'b0;
            socket_reg_offset_o <= 11'h000;
        end else begin
            socket_claim_o <= mem_req_i && memory_space_enable_i && socket_base_valid
                && socket_addr_match;
            socket_card16_sel_o <= (mem_addr_i[11:0] >= `SOCKET_CARD16_REGS_OFS);
            socket_reg_offset_o <= mem_addr_i[10:0] - 11'(`SOCKET_CARDBUS_REGS_OFS);
        end
    end

    // ------------------------------------------------------------------
    // Configuration forwarding
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fwd_type0_o <= 1'b0;
            fwd_type1_o <= 1'b0;
            primary_special_cycle_o <= 1'b0;
        end else begin
            fwd_type0_o <= cfg_type1_req_i && (cfg_type1_bus_i == secondary_bus_reg);
            fwd_type1_o <= cfg_type1_req_i && (cfg_type1_bus_i > secondary_bus_reg)
                && (cfg_type1_bus_i <= subordinate_bus_i);
            // Secondary type 1 requests are deliberately left undecoded.
            primary_special_cycle_o <= sec_type1_req_i && 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Primary master latency
    // ------------------------------------------------------------------
    latency_countdown u_latency_countdown (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .timer_value_i({latency_reg, `LATENCY_FRAC_BITS}),
        .burst_start_i(burst_start_i),
        .burst_active_i(burst_active_i),
        .grant_i(!grant_sync_reg[1]),
        .expired_o(latency_expired_o),
        .end_burst_o(end_burst_o)
    );

endmodule

/* File: cardbus_cfg_header_mid_assertions.sv */
// Port checker for the mid configuration header.
module cardbus_cfg_header_mid_checker (
    // Clock, reset and configuration reads
    input logic clock_i,
    input logic resetn_i,
    input logic cfg_read_i,
    input logic [7:0] cfg_addr_i,
    input logic [31:0] cfg_rdata_o,
    // Enables and error events
    input logic serr_enable_i,
    input logic parity_response_enable_i,
    input logic memory_space_enable_i,
    input logic card_serr_enable_i,
    input logic sec_perr_seen_as_master_i,
    input logic primary_serr_n_o,
    input logic primary_serr_oe_o,
    input logic primary_perr_request_o,
    // Decode, forwarding and burst
    input logic mem_req_i,
    input logic [31:0] mem_addr_i,
    input logic socket_claim_o,
    input logic socket_card16_sel_o,
    input logic [10:0] socket_reg_offset_o,
    input logic cfg_type1_req_i,
    input logic fwd_type0_o,
    input logic fwd_type1_o,
    input logic primary_special_cycle_o,
    input logic burst_active_i,
    input logic end_burst_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    wire rd_hdr = cfg_read_i && cfg_addr_i[7:2] == 6'h03;
    wire rd_base = cfg_read_i && cfg_addr_i[7:2] == 6'h04;
    wire rd_stat = cfg_read_i && cfg_addr_i[7:2] == 6'h05;
    a_cache_zero: assert property (rd_hdr |=> cfg_rdata_o[7:0] == 8'h00)
        else $error("cache size set");
    a_latency_low: assert property (rd_hdr |=> cfg_rdata_o[10:8] == 3'h0)
        else $error("latency low set");
    a_header_fixed: assert property (rd_hdr |=> cfg_rdata_o[31:16] == 16'h0002)
        else $error("header or self-test");
    a_base_low: assert property (rd_base |=> cfg_rdata_o[11:0] == 12'h000)
        else $error("base low set");
    a_status_fixed: assert property (rd_stat |=>
        cfg_rdata_o[26:25] == 2'b01 && cfg_rdata_o[23:16] == 8'h00)
        else $error("status fixed bits");
    a_claim_cause: assert property (socket_claim_o |->
        $past(mem_req_i) && $past(memory_space_enable_i))
        else $error("claim not enabled");
    a_socket_layout: assert property (socket_claim_o |->
        socket_card16_sel_o == $past(mem_addr_i[11])
        && socket_reg_offset_o == $past(mem_addr_i[10:0]))
        else $error("region split");
    a_fwd_cause: assert property ((fwd_type0_o || fwd_type1_o) |->
        $past(cfg_type1_req_i) && !(fwd_type0_o && fwd_type1_o))
        else $error("bad forward");
    a_no_special: assert property (!primary_special_cycle_o)
        else $error("special cycle");
    a_serr_gated: assert property (primary_serr_oe_o |-> !primary_serr_n_o
        && $past(serr_enable_i) && $past(card_serr_enable_i))
        else $error("serr not enabled");
    a_perr_follow: assert property (sec_perr_seen_as_master_i && parity_response_enable_i
        |=> primary_perr_request_o)
        else $error("perr missing");
    a_perr_gated: assert property (primary_perr_request_o |->
        $past(parity_response_enable_i) && $past(sec_perr_seen_as_master_i))
        else $error("perr not enabled");
    a_end_burst: assert property (end_burst_o |-> $past(burst_active_i))
        else $error("burst end idle");
endmodule

bind cardbus_cfg_header_mid cardbus_cfg_header_mid_checker chk (.*);

/* File: cardbus_cfg_pkg.sv */
// Types shared by the mid configuration header and its latency counter.
package cardbus_cfg_pkg;

    // ------------------------------------------------------------------
    // Primary burst latency states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_COUNT,
        BURST_EXPIRED
    } burst_state_e;

    typedef logic [7:0] bus_number_t;
    typedef logic [15:0] status_word_t;

endpackage

/* File: cfg_host_model.sv */
// Configuration master that issues single accesses to the header.
module cfg_host_model (
    // Clock
    input wire logic clock_i,
    // Access request
    output logic cfg_read_o,
    output logic cfg_write_o,
    output logic [7:0] cfg_addr_o,
    output logic [3:0] cfg_byte_en_o,
    output logic [31:0] cfg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cfg_read_o, cfg_write_o, cfg_addr_o, cfg_byte_en_o, cfg_wdata_o} = 46'h0;
    // Idle address, byte enable and data lines show the inverse of the last value; both strobes drop to zero.
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(posedge clock_i);
        {cfg_write_o, cfg_read_o, cfg_addr_o, cfg_byte_en_o, cfg_wdata_o} <= {w, !w, a, b, d};
        @(posedge clock_i);
        {cfg_write_o, cfg_read_o, cfg_addr_o, cfg_byte_en_o, cfg_wdata_o} <= {2'h0, ~{a, b, d}};
    endtask
endmodule

/* File: latency_countdown.sv */
// Primary bus master latency counter that ends a burst after grant loss.
`include "cardbus_cfg_consts.svh"

module latency_countdown
    import cardbus_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Programmed count and burst status
    input wire logic [7:0] timer_value_i,
    input wire logic burst_start_i,
    input wire logic burst_active_i,
    input wire logic grant_i,
    // Results
    output logic expired_o,
    output logic end_burst_o
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    burst_state_e state_reg;
    logic [7:0] count_reg;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= BURST_IDLE;
            count_reg <= 8'h00;
        end else if (burst_start_i) begin
            state_reg <= (timer_value_i == 8'h00) ? BURST_EXPIRED : BURST_COUNT;
            count_reg <= timer_value_i;
        end else if (!burst_active_i) begin
            state_reg <= BURST_IDLE;
        end else begin
            unique case (state_reg)
                BURST_IDLE: begin
                    state_reg <= BURST_IDLE;
                end
                BURST_COUNT: begin
                    count_reg <= count_reg - 8'h01;
                    if (count_reg == 8'h01) begin
                        state_reg <= BURST_EXPIRED;
                    end
                end
                BURST_EXPIRED: begin
                    state_reg <= BURST_EXPIRED;
                end
            endcase
        end
    end

    // A master still holding grant may keep bursting past expiry.
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            expired_o <= 1'b0;
            end_burst_o <= 1'b0;
        end else begin
            expired_o <= (state_reg == BURST_EXPIRED);
            end_burst_o <= burst_active_i && (state_reg == BURST_EXPIRED)
                && !grant_i;
        end
    end

endmodule

/* File: tb.sv */
// Self-checking bench for the mid configuration header.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, resetn_i = 1'b0;
    logic serr_en = 1'b1, pre = 1'b1, mse = 1'b1, cse = 1'b1, cserr_n = 1'b1;
    logic [7:0] sub_bus = 8'h00, t1_bus = 8'h00;
    logic [4:0] ev = 5'h00;
    logic mem_req = 1'b0, t1_req = 1'b0, sec_t1 = 1'b0;
    logic [31:0] mem_addr = 32'h0;
    logic b_start = 1'b0, b_act = 1'b0, gnt_n = 1'b0;
    logic hrd, hwr, ack, serr_n, serr_oe, perr_req, claim, c16, f0, f1, spec, lexp, endb;
    logic [7:0] haddr;
    logic [3:0] hbe;
    logic [31:0] hwd, rdata;
    logic [10:0] ofs;
    logic [31:0] exp_q[$];
    logic [15:0] bits [5] = '{16'h8000, 16'h2000, 16'h1000, 16'h0800, 16'h0100};
    int mismatches = 0, checks_done = 0, cycles = 0, serr_seen = 0;

    cfg_host_model host (.clock_i(clock_i), .cfg_read_o(hrd), .cfg_write_o(hwr),
        .cfg_addr_o(haddr), .cfg_byte_en_o(hbe), .cfg_wdata_o(hwd));
    cardbus_cfg_header_mid dut (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_read_i(hrd),
        .cfg_write_i(hwr), .cfg_addr_i(haddr), .cfg_byte_en_i(hbe), .cfg_wdata_i(hwd),
        .cfg_rdata_o(rdata), .cfg_ack_o(ack), .serr_enable_i(serr_en),
        .parity_response_enable_i(pre), .memory_space_enable_i(mse),
        .card_serr_enable_i(cse), .subordinate_bus_i(sub_bus), .sec_parity_error_i(ev[0]),
        .sec_perr_seen_as_master_i(ev[4]), .sec_master_abort_i(ev[1]),
        .sec_target_abort_rcvd_i(ev[2]), .sec_target_abort_sig_i(ev[3]),
        .card_serr_n_i(cserr_n), .primary_serr_n_o(serr_n), .primary_serr_oe_o(serr_oe),
        .primary_perr_request_o(perr_req), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
        .socket_claim_o(claim), .socket_card16_sel_o(c16), .socket_reg_offset_o(ofs),
        .cfg_type1_req_i(t1_req), .cfg_type1_bus_i(t1_bus), .sec_type1_req_i(sec_t1),
        .fwd_type0_o(f0), .fwd_type1_o(f1), .primary_special_cycle_o(spec),
        .burst_start_i(b_start), .burst_active_i(b_act), .grant_n_i(gnt_n),
        .latency_expired_o(lexp), .end_burst_o(endb));

    always #5 clock_i = ~clock_i;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 4'hf, $urandom);
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        exp_q.push_back(32'h0);
        host.access(1'b1, a, b, d);
    endtask

    task automatic probe(input logic [31:0] a, input logic ec, input logic es);
        @(posedge clock_i);
        {mem_req, mem_addr} <= {1'b1, a};
        @(posedge clock_i);
        {mem_req, mem_addr} <= {1'b0, ~a};
        @(negedge clock_i);
        check("socket_claim_o", ec, claim);
        if (ec) check("socket_card16_sel_o", es, c16);
        if (ec) check("socket_reg_offset_o", a[10:0], ofs);
    endtask

    task automatic fwd(input logic [7:0] b, input logic e0, input logic e1);
        @(posedge clock_i);
        {t1_req, sec_t1, t1_bus} <= {2'h3, b};
        @(posedge clock_i);
        {t1_req, sec_t1, t1_bus} <= {2'h0, ~b};
        @(negedge clock_i);
        check("fwd_type0_o", e0, f0);
        check("fwd_type1_o", e1, f1);
    endtask

    always @(negedge clock_i) begin
        if (ack === 1'b1) begin
            if (exp_q.size() == 0) check("cfg_ack_o", 32'h0, 32'h1);
            else check("cfg_rdata_o", exp_q.pop_front(), rdata);
        end
        if (serr_oe === 1'b1) serr_seen++;
    end

    always @(posedge clock_i) begin
        if (++cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] d, base;
        logic [7:0] s;
        int n;
        void'($urandom(83));
        repeat (6) @(posedge clock_i);
        resetn_i <= 1'b1;
        cfg_rd(8'h0c, 32'h0002_0000);
        cfg_rd(8'h10, 32'h0);
        cfg_rd(8'h14, 32'h0200_0000);
        cfg_rd(8'h18, 32'h0);
        probe(32'h0000_0804, 1'b0, 1'b0);
        d = $urandom;
        cfg_wr(8'h0c, 4'hf, d);
        cfg_rd(8'h0c, {16'h0002, d[15:11], 3'b000, 8'h00});
        d = $urandom | 32'h1000;
        base = {d[31:12], 12'h000};
        cfg_wr(8'h10, 4'hf, d);
        cfg_wr(8'h10, 4'h1, 32'hffff_ffff);
        cfg_rd(8'h10, base);
        $display("registers done");
        probe(base | 32'h804, 1'b1, 1'b1);
        probe(base | 32'h004, 1'b1, 1'b0);
        probe(base + 32'h1000, 1'b0, 1'b0);
        @(posedge clock_i);
        mse <= 1'b0;
        probe(base | 32'h804, 1'b0, 1'b0);
        $display("socket decode done");
        s = 8'($urandom_range(250, 1));
        d = $urandom;
        @(posedge clock_i);
        sub_bus <= s + 8'd2;
        cfg_wr(8'h18, 4'h7, {16'hffff, s, d[7:0]});
        cfg_rd(8'h18, {8'h00, s + 8'd2, s, d[7:0]});
        fwd(s, 1'b1, 1'b0);
        fwd(s + 8'd1, 1'b0, 1'b1);
        fwd(s + 8'd2, 1'b0, 1'b1);
        fwd(s + 8'd3, 1'b0, 1'b0);
        fwd(s - 8'd1, 1'b0, 1'b0);
        $display("forwarding done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            ev <= 5'(1 << i);
            @(posedge clock_i);
            ev <= 5'h00;
            cfg_rd(8'h14, {16'h0200 | bits[i], 16'h0});
            cfg_wr(8'h14, 4'hc, 32'h0);
            cfg_rd(8'h14, {16'h0200 | bits[i], 16'h0});
            cfg_wr(8'h14, 4'hc, 32'hffff_0000);
            cfg_rd(8'h14, 32'h0200_0000);
        end
        @(posedge clock_i);
        pre <= 1'b0;
        ev <= 5'h10;
        @(posedge clock_i);
        ev <= 5'h00;
        cfg_rd(8'h14, 32'h0200_0000);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_i);
            serr_en <= (k == 0);
            cserr_n <= 1'b0;
            repeat (4) @(posedge clock_i);
            cserr_n <= 1'b1;
            repeat (3) @(posedge clock_i);
            cfg_rd(8'h14, 32'h4200_0000);
            cfg_wr(8'h14, 4'hc, 32'h4000_0000);
        end
        check("serr_pulses", 32'h1, 32'(serr_seen));
        $display("status done");
        cfg_wr(8'h0c, 4'h2, 32'h0000_1000);
        cfg_rd(8'h0c, 32'h0002_1000);
        @(posedge clock_i);
        b_start <= 1'b1;
        b_act <= 1'b1;
        @(posedge clock_i);
        b_start <= 1'b0;
        repeat (30) @(posedge clock_i);
        @(negedge clock_i);
        check("latency_expired_o", 32'h1, lexp);
        check("end_burst_o", 32'h0, endb);
        @(posedge clock_i);
        gnt_n <= 1'b1;
        repeat (4) @(negedge clock_i);
        check("end_burst_o", 32'h1, endb);
        @(posedge clock_i);
        b_act <= 1'b0;
        repeat (4) @(posedge clock_i);
        b_start <= 1'b1;
        b_act <= 1'b1;
        @(posedge clock_i);
        b_start <= 1'b0;
        n = 0;
        while (endb !== 1'b1 && n < 40) begin
            @(negedge clock_i);
            n++;
        end
        check("burst_length", 32'h1, 32'(n >= 16 && n <= 22));
        $display("latency done");
        repeat (4) @(posedge clock_i);
        check("pending_reads", 32'h0, 32'(exp_q.size()));
        stop_test();
    end
endmodule
